// file: src/prox_enable_timing.v
`timescale 1ns/100ps
`include "prox_regs_map.vh"
module prox_enable_timing #(
  parameter STEP_CYCLES = `STEP_CYCLES
) (
  input wire sys_clk_in, // 250 MHz clock
  input wire srst_in, // sync reset, high
  input wire wr_en_in, // register write strobe
  input wire rd_en_in, // register read strobe
  input wire sf_en_in, // special function strobe
  input wire [4:0] addr_in, // register address or sf code
  input wire [7:0] wdata_in, // write data
  input wire thresh_hit_in, // result outside thresholds
  output reg [7:0] rdata_out, // read data
  output reg osc_on_out, // oscillator running
  output reg integrating_out, // proximity integration active
  output reg waiting_out, // wait period active
  output reg irq_pending_out, // interrupt pending status
  output reg irq_out // interrupt to host
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_INTEG = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_SLEEP = 4'b1000;

  reg [7:0] enable_r;
  reg [7:0] integ_r;
  reg [7:0] wait_r;
  reg [7:0] config_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg start_nxt;
  reg [12:0] steps_nxt;
  reg [7:0] enable_nxt;
  reg [7:0] integ_nxt;
  reg [7:0] wait_nxt;
  reg [7:0] config_nxt;
  reg pending_nxt;
  reg irq_nxt;
  wire done;
  wire power_up_osc = enable_r[`BIT_POWER_UP_OSC];
  wire proximity_on = enable_r[`BIT_PROXIMITY_ON];
  wire wait_on = enable_r[`BIT_WAIT_ON];
  wire prox_irq_mask = enable_r[`BIT_PROX_IRQ_MASK];
  wire sleep_after_irq = enable_r[`BIT_SLEEP_AFTER_IRQ];
  wire run_on = power_up_osc && proximity_on;
  wire clr_cmd = sf_en_in && (addr_in == `SF_IRQ_CLEAR);
  wire set_irq = thresh_hit_in && run_on && state_r == ST_INTEG;

  // integration counts 256 minus the register value; wait counts that, or twelve times it with BIT_WAIT_X12 set
  function [12:0] wait_steps;
    input [7:0] wv;
    input lng;
    reg [12:0] base;
    begin
      base = 13'h0100 - {5'h00, wv};
      wait_steps = lng ? base * 13'h000C : base;
    end
  endfunction

  function [12:0] integ_steps;
    input [7:0] iv;
    begin
      integ_steps = 13'h0100 - {5'h00, iv};
    end
  endfunction

  // register writes; reserved bits always land as zero
  always @* begin
    enable_nxt = enable_r;
    integ_nxt = integ_r;
    wait_nxt = wait_r;
    config_nxt = config_r;
    if (wr_en_in) begin
      case (addr_in)
        `FUNCTION_ENABLE_OFS: enable_nxt = wdata_in & `ENABLE_WMASK;
        `INTEGRATION_PERIOD_OFS: integ_nxt = wdata_in;
        `WAIT_PERIOD_OFS: wait_nxt = wdata_in;
        `WAIT_CONFIG_OFS: config_nxt = wdata_in & `CONFIG_WMASK;
        default: ;
      endcase
    end
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      enable_r <= `FUNCTION_ENABLE_RST;
      integ_r <= `INTEGRATION_PERIOD_RST;
      wait_r <= `WAIT_PERIOD_RST;
      config_r <= `WAIT_CONFIG_RST;
    end else begin
      enable_r <= enable_nxt;
      integ_r <= integ_nxt;
      wait_r <= wait_nxt;
      config_r <= config_nxt;
    end
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_en_in) begin
      case (addr_in)
        `FUNCTION_ENABLE_OFS: rdata_out <= enable_r;
        `INTEGRATION_PERIOD_OFS: rdata_out <= integ_r;
        `WAIT_PERIOD_OFS: rdata_out <= wait_r;
        `WAIT_CONFIG_OFS: rdata_out <= config_r;
        default: rdata_out <= 8'h00;
      endcase
    end
  end

  // pending flag: set wins over clear
  always @* begin
    pending_nxt = irq_pending_out;
    if (set_irq) begin
      pending_nxt = 1'b1;
    end else if (clr_cmd) begin
      pending_nxt = 1'b0;
    end
    irq_nxt = prox_irq_mask && pending_nxt;
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      irq_pending_out <= 1'b0;
    end else begin
      irq_pending_out <= pending_nxt;
    end
  end

  // sequencer: integrate, optional wait, sleep on a pending interrupt
  always @* begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    steps_nxt = integ_steps(integ_r);
    case (state_r)
      ST_IDLE: begin
        if (run_on) begin
          state_nxt = ST_INTEG;
          start_nxt = 1'b1;
        end
      end
      ST_INTEG: begin
        if (done) begin
          if (sleep_after_irq && prox_irq_mask && pending_nxt) begin
            state_nxt = ST_SLEEP;
          end else if (wait_on) begin
            state_nxt = ST_WAIT;
            start_nxt = 1'b1;
            steps_nxt = wait_steps(wait_r, config_r[`BIT_WAIT_X12]);
          end else begin
            state_nxt = ST_INTEG;
            start_nxt = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (done) begin
          state_nxt = ST_INTEG;
          start_nxt = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (!irq_pending_out) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (!run_on) begin
      state_nxt = ST_IDLE;
      start_nxt = 1'b0;
    end
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_r <= ST_IDLE;
      osc_on_out <= 1'b0;
      integrating_out <= 1'b0;
      waiting_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      osc_on_out <= power_up_osc;
      integrating_out <= state_nxt == ST_INTEG;
      waiting_out <= state_nxt == ST_WAIT;
      irq_out <= irq_nxt;
    end
  end

  step_timer #(
    .STEP_CYCLES(STEP_CYCLES),
    .CW(20)
  ) step_timer_inst (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .start_in(start_nxt),
    .abort_in(!run_on),
    .steps_in(steps_nxt),
    .done_out(done)
  );
endmodule

// file: shared/prox_regs_map.vh
`ifndef PROX_REGS_MAP_VH
`define PROX_REGS_MAP_VH
`define FUNCTION_ENABLE_OFS 5'h00
`define INTEGRATION_PERIOD_OFS 5'h02
`define WAIT_PERIOD_OFS 5'h03
`define WAIT_CONFIG_OFS 5'h0D
`define FUNCTION_ENABLE_RST 8'h00
`define INTEGRATION_PERIOD_RST 8'hFF
`define WAIT_PERIOD_RST 8'hFF
`define WAIT_CONFIG_RST 8'h00
`define SF_IRQ_CLEAR 5'h05
`define BIT_POWER_UP_OSC 0
`define BIT_PROXIMITY_ON 2
`define BIT_WAIT_ON 3
`define BIT_PROX_IRQ_MASK 5
`define BIT_SLEEP_AFTER_IRQ 6
`define BIT_WAIT_X12 1
`define ENABLE_WMASK 8'h6D
`define CONFIG_WMASK 8'h02
`define STEP_TIME_PS 2730000
`define CLK_PERIOD_PS 4000
`define STEP_CYCLES (`STEP_TIME_PS / `CLK_PERIOD_PS)
`define LONG_WAIT_FACTOR 12
`endif

// file: src/step_timer.v
`timescale 1ns/100ps
// counts a number of steps, each step_cycles clocks long
module step_timer #(
  parameter STEP_CYCLES = 682,
  parameter CW = 20
) (
  input wire sys_clk_in, // clock
  input wire srst_in, // sync reset
  input wire start_in, // load and run
  input wire abort_in, // stop counting
  input wire [12:0] steps_in, // step count
  output wire done_out // high in the last clock of the count
);
  localparam [31:0] LAST_CYC_WIDE = STEP_CYCLES - 1;
  localparam [CW-1:0] LAST_CYC = LAST_CYC_WIDE[CW-1:0];
  reg [CW-1:0] cyc_r;
  reg [12:0] steps_r;
  reg busy_r;
  // flagged in the final clock so a follow-on phase starts with no gap
  assign done_out = busy_r && (cyc_r == LAST_CYC) && (steps_r <= 13'h0001);
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      cyc_r <= {CW{1'b0}};
      steps_r <= 13'h0000;
      busy_r <= 1'b0;
    end else begin
      if (abort_in) begin
        busy_r <= 1'b0;
      end else if (start_in) begin
        busy_r <= 1'b1;
        steps_r <= steps_in;
        cyc_r <= {CW{1'b0}};
      end else if (busy_r) begin
        if (cyc_r == LAST_CYC) begin
          cyc_r <= {CW{1'b0}};
          if (steps_r <= 13'h0001) begin
            busy_r <= 1'b0;
          end else begin
            steps_r <= steps_r - 13'h0001;
          end
        end else begin
          cyc_r <= cyc_r + 1'b1;
        end
      end
    end
  end
endmodule

// file: verification/prox_chk_assertions.sv
`timescale 1ns/100ps
module prox_chk (
  input logic sys_clk_in, srst_in, wr_en_in, rd_en_in, // clock, reset, strobes
  input logic sf_en_in, thresh_hit_in, osc_on_out, integrating_out, // control
  input logic waiting_out, irq_pending_out, irq_out, // status
  input logic [4:0] addr_in, // address
  input logic [7:0] wdata_in, rdata_out // data
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  wire clr = sf_en_in && addr_in == 5'h05;
  a_irq_clear: assert property (clr && !thresh_hit_in |=> !irq_pending_out) else $error("clear");
  a_irq_hold: assert property (irq_pending_out && !clr |=> irq_pending_out) else $error("hold");
  a_pend_cause: assert property ($rose(irq_pending_out) |-> $past(thresh_hit_in)) else $error("cause");
  a_irq_mask: assert property (irq_out |-> irq_pending_out) else $error("mask");
  a_osc_write: assert property (wr_en_in && addr_in == 5'h00 ##1 !wr_en_in
    |=> osc_on_out == $past(wdata_in[0], 2)) else $error("osc");
  a_idle_off: assert property (!osc_on_out && !$past(osc_on_out)
    |-> !waiting_out && !integrating_out) else $error("idle");
  a_phase_excl: assert property (!(integrating_out && waiting_out)) else $error("phase");
  a_rsvd_zero: assert property (rd_en_in && !wr_en_in && addr_in == 5'h00
    |=> !rdata_out[7] && !rdata_out[4] && !rdata_out[1]) else $error("rsvd");
  a_rd_hold: assert property (!rd_en_in |=> $stable(rdata_out)) else $error("rdata");
  c_irq: cover property (irq_out);
  c_clear: cover property (clr && irq_pending_out);
  c_wait: cover property ($rose(waiting_out));
endmodule
bind prox_enable_timing prox_chk prox_chk_inst (.*);

// file: verification/prox_result_model.sv
`timescale 1ns/100ps
// stands in for the threshold compare on the result path
module prox_result_model (
  input wire logic sys_clk_in, // clock
  input wire logic integrating_in, // integration active
  input wire logic arm_in, // result outside window
  output logic hit_out // to thresh_hit_in
);
  always @(posedge sys_clk_in) hit_out <= arm_in && integrating_in;
endmodule

// file: verification/test_prox_enable_timing.sv
`timescale 1ns/100ps
module test_prox_enable_timing;
  logic sys_clk_in = 0, srst_in = 1, wr_en_in = 0, rd_en_in = 0, sf_en_in = 0, arm = 0, hit, sel = 0;
  logic [4:0] addr_in = 0;
  logic [7:0] wdata_in = 0, rdata_out;
  logic osc_on_out, integrating_out, waiting_out, irq_pending_out, irq_out;
  int n_fail = 0, total_checks = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  prox_enable_timing #(.STEP_CYCLES(4)) prox_enable_timing_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .sf_en_in(sf_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .thresh_hit_in(hit), .rdata_out(rdata_out), .osc_on_out(osc_on_out), .integrating_out(integrating_out),
    .waiting_out(waiting_out), .irq_pending_out(irq_pending_out), .irq_out(irq_out));
  prox_result_model prox_result_model_inst (.sys_clk_in(sys_clk_in), .integrating_in(integrating_out),
    .arm_in(arm), .hit_out(hit));
  wire phase = sel ? waiting_out : integrating_out;
  task chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task op(input logic [1:0] k, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    {sf_en_in, wr_en_in} <= k;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    {sf_en_in, wr_en_in} <= 2'b00;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    rd_en_in <= 1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_en_in <= 0;
    @(posedge sys_clk_in) #1;
    chk(rdata_out, e);
  endtask
  task meas(input logic s, input int e);
    int n;
    sel = s;
    #1;
    n = 0;
    while (phase && n < 2000) begin
      @(posedge sys_clk_in) #1;
      n++;
    end
    n = 0;
    while (!phase && n < 2000) begin
      @(posedge sys_clk_in) #1;
      n++;
    end
    n = 0;
    while (phase && n < 2000) begin
      @(posedge sys_clk_in) #1;
      n++;
    end
    chk(n, e);
  endtask
  task stop_test;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #40000;
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 0;
    rd(5'h00, 8'h00);
    rd(5'h02, 8'hFF);
    rd(5'h03, 8'hFF);
    rd(5'h0D, 8'h00);
    rd(5'h01, 8'h00);
    $display("reset values done");
    op(1, 5'h00, 8'hFF);
    rd(5'h00, 8'h6D);
    op(1, 5'h00, 8'h00);
    op(1, 5'h03, 8'hFE);
    op(1, 5'h02, 8'hFE);
    op(1, 5'h00, 8'h0D);
    meas(0, 8);
    meas(1, 8);
    op(1, 5'h0D, 8'hFF);
    rd(5'h0D, 8'h02);
    meas(0, 8);
    meas(1, 96);
    $display("timing done");
    op(1, 5'h0D, 8'h00);
    op(1, 5'h02, 8'hFF);
    op(1, 5'h00, 8'h25);
    arm <= 1;
    repeat (30) @(posedge sys_clk_in);
    arm <= 0;
    #1 chk(irq_out, 1);
    op(2, 5'h06, 8'h00);
    #1 chk(irq_pending_out, 1);
    op(2, 5'h05, 8'h00);
    #1 chk(irq_pending_out, 0);
    arm <= 1;
    repeat (30) @(posedge sys_clk_in);
    arm <= 0;
    #1 chk(irq_pending_out, 1);
    op(1, 5'h00, 8'h05);
    repeat (2) @(posedge sys_clk_in) #1;
    chk(irq_out, 0);
    op(2, 5'h05, 8'h00);
    $display("interrupt done");
    op(1, 5'h00, 8'h6D);
    arm <= 1;
    repeat (30) @(posedge sys_clk_in);
    arm <= 0;
    repeat (60) @(posedge sys_clk_in) #1;
    chk(integrating_out, 0);
    op(2, 5'h05, 8'h00);
    meas(0, 4);
    op(1, 5'h00, 8'h00);
    repeat (3) @(posedge sys_clk_in) #1;
    chk({osc_on_out, integrating_out}, 0);
    $display("sleep and power done");
    stop_test;
  end
endmodule
